// ==== common/pwg_defs.vh ====
`ifndef PWG_DEFS_VH
`define PWG_DEFS_VH
// register byte offsets, one block of eight words per generator
`define PWG_GEN_STRIDE   8'h20
`define PWG_OFF_CTL      8'h00
`define PWG_OFF_LOAD     8'h04
`define PWG_OFF_CMPA     8'h08
`define PWG_OFF_CMPB     8'h0C
`define PWG_OFF_ACTA     8'h10
`define PWG_OFF_ACTB     8'h14
`define PWG_OFF_STAT     8'h18
`define PWG_OFF_UPD      8'h40
// control register fields
`define PWG_CTL_EN       0
`define PWG_CTL_UPDOWN   1
`define PWG_CTL_SYNCLD   2
`define PWG_CTL_SYNCCMP  3
// action field positions, two bits each
`define PWG_ACT_ZERO     1:0
`define PWG_ACT_LOAD     3:2
`define PWG_ACT_AUP      5:4
`define PWG_ACT_ADN      7:6
`define PWG_ACT_BUP      9:8
`define PWG_ACT_BDN      11:10
// action codes
`define PWG_A_NONE       2'h0
`define PWG_A_TOGGLE     2'h1
`define PWG_A_LOW        2'h2
`define PWG_A_HIGH       2'h3
`define PWG_CNT_RESET    16'h0000
`define PWG_RESP_OKAY    2'h0
`define PWG_RESP_SLVERR  2'h2
`endif

// ==== core/pwg_top.v ====
`include "pwg_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module pwg_top (
  input  wire        CLK_SYS,         // system clock 100 MHz
  input  wire        RST_N,           // async reset, active low
  input  wire [7:0]  S_AXI_AWADDR,    // write address
  input  wire        S_AXI_AWVALID,   // write address valid
  output reg         S_AXI_AWREADY,   // write address ready
  input  wire [31:0] S_AXI_WDATA,     // write data
  input  wire [3:0]  S_AXI_WSTRB,     // write strobes
  input  wire        S_AXI_WVALID,    // write data valid
  output reg         S_AXI_WREADY,    // write data ready
  output reg  [1:0]  S_AXI_BRESP,     // write response
  output reg         S_AXI_BVALID,    // write response valid
  input  wire        S_AXI_BREADY,    // write response ready
  input  wire [7:0]  S_AXI_ARADDR,    // read address
  input  wire        S_AXI_ARVALID,   // read address valid
  output reg         S_AXI_ARREADY,   // read address ready
  output reg  [31:0] S_AXI_RDATA,     // read data
  output reg  [1:0]  S_AXI_RRESP,     // read response
  output reg         S_AXI_RVALID,    // read valid
  input  wire        S_AXI_RREADY,    // read ready
  output wire [1:0]  PIN_OUT_GEN_A,   // gen_output_a per generator
  output wire [1:0]  PIN_OUT_GEN_B,   // gen_output_b per generator
  output wire [1:0]  EVT_ZERO,        // zero event pulses
  output wire [1:0]  EVT_LOAD,        // load event pulses
  output wire [1:0]  EVT_CMPA,        // comparator A match pulses
  output wire [1:0]  EVT_CMPB,        // comparator B match pulses
  output wire [1:0]  CNT_DIR          // direction, high ascending
);

  // write channel capture: address and data may arrive in either order
  reg        aw_have_r;
  reg  [7:0] aw_addr_r;
  reg        w_have_r;
  reg [31:0] w_data_r;
  reg  [3:0] w_strb_r;
  wire       wr_go = aw_have_r & w_have_r & ~S_AXI_BVALID;
  wire [7:0] wr_off = aw_addr_r & 8'h1F;
  wire       wr_gsel = aw_addr_r[5];
  wire       wr_in_gen = (aw_addr_r[7:6] == 2'h0);
  wire       wr_upd = (aw_addr_r == `PWG_OFF_UPD);
  wire       wr_ok = (wr_in_gen & (wr_off <= `PWG_OFF_ACTB)
                      & (wr_off[1:0] == 2'h0)) | wr_upd;
  // global synchronized-update request, a self-clearing write
  wire       sync_req = wr_go & wr_upd & w_strb_r[0] & w_data_r[0];

  wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                       {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_have_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_have_r      <= 1'b0;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PWG_RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= ~aw_have_r & ~S_AXI_AWREADY & ~S_AXI_BVALID;
      S_AXI_WREADY  <= ~w_have_r & ~S_AXI_WREADY & ~S_AXI_BVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID & S_AXI_WREADY)
      begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `PWG_RESP_OKAY : `PWG_RESP_SLVERR;
      end
      else if (S_AXI_BVALID & S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // per-generator signals gathered for the read mux
  wire [31:0] rd_ctl  [0:1];
  wire [31:0] rd_load [0:1];
  wire [31:0] rd_cmpa [0:1];
  wire [31:0] rd_cmpb [0:1];
  wire [31:0] rd_acta [0:1];
  wire [31:0] rd_actb [0:1];
  wire [31:0] rd_stat [0:1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_blk
      reg  [3:0]  ctl_r;
      reg  [15:0] load_sh_r, cmpa_sh_r, cmpb_sh_r; // software copies
      reg  [15:0] load_r, cmpa_r, cmpb_r;          // active values
      reg         ld_pend_r, cmp_pend_r, ld_arm_r, cmp_arm_r;
      reg  [11:0] acta_r, actb_r;
      reg  [15:0] cnt_r;
      reg         dir_r, out_a_r, out_b_r;
      reg         zero_r, load_ev_r, ma_r, mb_r;
      reg  [1:0]  act_a_nxt, act_b_nxt;
      reg         a_nxt, b_nxt;
      reg  [15:0] cnt_nxt;
      reg         dir_nxt;
      wire        we = wr_go & wr_in_gen & (wr_gsel == g);
      wire        en = ctl_r[`PWG_CTL_EN];
      wire        ud = ctl_r[`PWG_CTL_UPDOWN];
      wire [31:0] wd = w_data_r & wmask;
      wire        at_zero = (cnt_r == 16'h0000);
      wire        at_load = (cnt_r == load_r);
      wire        ev_z = en & at_zero;
      wire        ev_l = en & at_load;
      wire        ev_a = en & (cnt_r == cmpa_r) & (cmpa_r <= load_r);
      wire        ev_b = en & (cnt_r == cmpb_r) & (cmpb_r <= load_r);
      // new period length must be the one reloaded at this very zero
      wire        ld_apply = ld_pend_r & ld_arm_r & (at_zero | ~en);
      wire [15:0] ld_eff = ld_apply ? load_sh_r : load_r;

      // counter and direction
      always @*
      begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (!en)
        begin
          cnt_nxt = `PWG_CNT_RESET;
          dir_nxt = 1'b0;
        end
        else if (!ud)
        begin
          dir_nxt = 1'b0;
          cnt_nxt = at_zero ? ld_eff : cnt_r - 16'h0001;
        end
        else if (dir_r)
        begin
          if (cnt_r >= load_r)
          begin
            dir_nxt = 1'b0;
            cnt_nxt = (load_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
          end
          else
            cnt_nxt = cnt_r + 16'h0001;
        end
        else
        begin
          if (at_zero)
          begin
            dir_nxt = 1'b1;
            cnt_nxt = (ld_eff == 16'h0000) ? 16'h0000 : 16'h0001;
          end
          else
            cnt_nxt = cnt_r - 16'h0001;
        end
      end

      // event to action selection; zero or load masks matches
      always @*
      begin
        act_a_nxt = `PWG_A_NONE;
        act_b_nxt = `PWG_A_NONE;
        if (ev_z)
        begin
          act_a_nxt = acta_r[`PWG_ACT_ZERO];
          act_b_nxt = actb_r[`PWG_ACT_ZERO];
        end
        else if (ev_l)
        begin
          act_a_nxt = acta_r[`PWG_ACT_LOAD];
          act_b_nxt = actb_r[`PWG_ACT_LOAD];
        end
        else
        begin
          // down mode: direction is low, only down matches reach here
          if (ev_a)
            act_a_nxt = dir_r ? acta_r[`PWG_ACT_AUP] : acta_r[`PWG_ACT_ADN];
          if (ev_b)
            act_b_nxt = dir_r ? actb_r[`PWG_ACT_BUP] : actb_r[`PWG_ACT_BDN];
        end
        case (act_a_nxt)
          `PWG_A_TOGGLE: a_nxt = ~out_a_r;
          `PWG_A_LOW:    a_nxt = 1'b0;
          `PWG_A_HIGH:   a_nxt = 1'b1;
          default:       a_nxt = out_a_r;
        endcase
        case (act_b_nxt)
          `PWG_A_TOGGLE: b_nxt = ~out_b_r;
          `PWG_A_LOW:    b_nxt = 1'b0;
          `PWG_A_HIGH:   b_nxt = 1'b1;
          default:       b_nxt = out_b_r;
        endcase
        if (!en)
        begin
          a_nxt = 1'b0;
          b_nxt = 1'b0;
        end
      end

      always @(posedge CLK_SYS or negedge RST_N)
      begin
        if (!RST_N)
        begin
          ctl_r <= 4'h0;
          load_sh_r <= 16'h0000;
          cmpa_sh_r <= 16'h0000;
          cmpb_sh_r <= 16'h0000;
          load_r <= 16'h0000;
          cmpa_r <= 16'h0000;
          cmpb_r <= 16'h0000;
          ld_pend_r <= 1'b0;
          cmp_pend_r <= 1'b0;
          ld_arm_r <= 1'b0;
          cmp_arm_r <= 1'b0;
          acta_r <= 12'h000;
          actb_r <= 12'h000;
          cnt_r <= `PWG_CNT_RESET;
          dir_r <= 1'b0;
          out_a_r <= 1'b0;
          out_b_r <= 1'b0;
          zero_r <= 1'b0;
          load_ev_r <= 1'b0;
          ma_r <= 1'b0;
          mb_r <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          dir_r <= dir_nxt;
          out_a_r <= a_nxt;
          out_b_r <= b_nxt;
          zero_r <= ev_z;
          load_ev_r <= ev_l;
          ma_r <= ev_a;
          mb_r <= ev_b;
          // apply pending values at zero; arm blocks a zero-cycle write
          if (ld_apply)
          begin
            load_r <= load_sh_r;
            ld_pend_r <= 1'b0;
            ld_arm_r <= 1'b0;
          end
          if (cmp_pend_r & cmp_arm_r & (at_zero | ~en))
          begin
            cmpa_r <= cmpa_sh_r;
            cmpb_r <= cmpb_sh_r;
            cmp_pend_r <= 1'b0;
            cmp_arm_r <= 1'b0;
          end
          if (ld_pend_r & (~ctl_r[`PWG_CTL_SYNCLD] | sync_req))
            ld_arm_r <= 1'b1;
          if (cmp_pend_r & (~ctl_r[`PWG_CTL_SYNCCMP] | sync_req))
            cmp_arm_r <= 1'b1;
          if (we & (wr_off == `PWG_OFF_CTL))
            ctl_r <= (ctl_r & ~wmask[3:0]) | wd[3:0];
          if (we & (wr_off == `PWG_OFF_LOAD))
          begin
            load_sh_r <= (load_sh_r & ~wmask[15:0]) | wd[15:0];
            ld_pend_r <= 1'b1;
            ld_arm_r <= 1'b0;
          end
          if (we & ((wr_off == `PWG_OFF_CMPA) | (wr_off == `PWG_OFF_CMPB)))
          begin
            if (wr_off == `PWG_OFF_CMPA)
              cmpa_sh_r <= (cmpa_sh_r & ~wmask[15:0]) | wd[15:0];
            else
              cmpb_sh_r <= (cmpb_sh_r & ~wmask[15:0]) | wd[15:0];
            cmp_pend_r <= 1'b1;
            cmp_arm_r <= 1'b0;
          end
          if (we & (wr_off == `PWG_OFF_ACTA))
            acta_r <= (acta_r & ~wmask[11:0]) | wd[11:0];
          if (we & (wr_off == `PWG_OFF_ACTB))
            actb_r <= (actb_r & ~wmask[11:0]) | wd[11:0];
        end
      end

      assign rd_ctl[g]  = {28'h0000000, ctl_r};
      assign rd_load[g] = {16'h0000, load_sh_r};
      assign rd_cmpa[g] = {16'h0000, cmpa_sh_r};
      assign rd_cmpb[g] = {16'h0000, cmpb_sh_r};
      assign rd_acta[g] = {20'h00000, acta_r};
      assign rd_actb[g] = {20'h00000, actb_r};
      assign rd_stat[g] = {12'h000, cmp_pend_r, ld_pend_r, out_b_r,
                           dir_r, cnt_r};
      assign PIN_OUT_GEN_A[g] = out_a_r;
      assign PIN_OUT_GEN_B[g] = out_b_r;
      assign EVT_ZERO[g] = zero_r;
      assign EVT_LOAD[g] = load_ev_r;
      assign EVT_CMPA[g] = ma_r;
      assign EVT_CMPB[g] = mb_r;
      assign CNT_DIR[g]  = dir_r;
    end
  endgenerate

  // read channel, answer one cycle after the address is taken
  reg  [31:0] rd_mux;
  wire [4:0]  r_off = S_AXI_ARADDR[4:0];
  wire        r_g = S_AXI_ARADDR[5];
  reg         r_ok;
  always @*
  begin
    rd_mux = 32'h00000000;
    r_ok = (S_AXI_ARADDR[7:6] == 2'h0);
    case (r_off)
      5'h00:   rd_mux = rd_ctl[r_g];
      5'h04:   rd_mux = rd_load[r_g];
      5'h08:   rd_mux = rd_cmpa[r_g];
      5'h0C:   rd_mux = rd_cmpb[r_g];
      5'h10:   rd_mux = rd_acta[r_g];
      5'h14:   rd_mux = rd_actb[r_g];
      5'h18:   rd_mux = rd_stat[r_g];
      default: r_ok = 1'b0;
    endcase
    if (S_AXI_ARADDR == `PWG_OFF_UPD)
    begin
      rd_mux = 32'h00000000;
      r_ok = 1'b1;
    end
    if (!r_ok)
      rd_mux = 32'h00000000;
  end

  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `PWG_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_mux;
        S_AXI_RRESP  <= r_ok ? `PWG_RESP_OKAY : `PWG_RESP_SLVERR;
      end
      else if (S_AXI_RVALID & S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // pwg_top
`default_nettype wire

// ==== bench/pwg_top_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwg_top_monitor (
  input wire logic        CLK_SYS,       // clock
  input wire logic        RST_N,         // reset, active low
  input wire logic [7:0]  S_AXI_AWADDR,  // write address
  input wire logic        S_AXI_AWVALID, // aw valid
  input wire logic        S_AXI_AWREADY, // aw ready
  input wire logic [31:0] S_AXI_WDATA,   // write data
  input wire logic        S_AXI_WVALID,  // w valid
  input wire logic        S_AXI_WREADY,  // w ready
  input wire logic        S_AXI_ARVALID, // ar valid
  input wire logic        S_AXI_ARREADY, // ar ready
  input wire logic        S_AXI_RVALID,  // r valid
  input wire logic [1:0]  S_AXI_RRESP,   // r response
  input wire logic [1:0]  EVT_ZERO,      // zero events
  input wire logic [1:0]  EVT_LOAD,      // load events
  input wire logic [1:0]  EVT_CMPA,      // match a events
  input wire logic [1:0]  EVT_CMPB,      // match b events
  input wire logic [1:0]  CNT_DIR,       // direction
  input wire logic [1:0]  PIN_OUT_GEN_A  // output a
);
  logic [7:0] wa_r;
  logic [1:0] ctl_r;
  wire logic       aw_hs  = S_AXI_AWVALID & S_AXI_AWREADY;
  wire logic [7:0] w_addr = aw_hs ? S_AXI_AWADDR : wa_r;

  // snooped gen0 mode; assumes address taken no later than data
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wa_r <= 8'h00;
      ctl_r <= 2'h0;
    end
    else
    begin
      if (aw_hs)
        wa_r <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY && w_addr == 8'h00)
        ctl_r <= S_AXI_WDATA[1:0];
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_zero_pulse: assert property (EVT_ZERO[0] |=> !EVT_ZERO[0])
    else $error("zero event wider than one cycle");
  a_load_pulse: assert property (EVT_LOAD[1] |=> !EVT_LOAD[1])
    else $error("load event wider than one cycle");
  a_match_pulse: assert property (EVT_CMPA[0] |=> !EVT_CMPA[0])
    else $error("match event wider than one cycle");
  a_matchb_pulse: assert property (EVT_CMPB[0] |=> !EVT_CMPB[0])
    else $error("match b event wider than one cycle");
  a_down_reload: assert property ((ctl_r == 2'h1 &&
    $past(ctl_r, 3) == 2'h1 && EVT_ZERO[0]) |=> EVT_LOAD[0])
    else $error("load event does not follow zero event");
  a_dir_down: assert property ((!ctl_r[1] &&
    !$past(ctl_r[1], 3)) |-> !CNT_DIR[0])
    else $error("direction high in down mode");
  a_dir_fall: assert property ((ctl_r == 2'h3 &&
    $past(ctl_r, 3) == 2'h3 && EVT_LOAD[0]) |-> ##[0:2] !CNT_DIR[0])
    else $error("no descent after load");
  a_dir_rise: assert property ((ctl_r == 2'h3 &&
    $past(ctl_r, 3) == 2'h3 && EVT_ZERO[0]) |-> ##[0:2] CNT_DIR[0])
    else $error("no ascent after zero");
  a_idle_quiet: assert property ((!ctl_r[0] &&
    !$past(ctl_r[0], 3)) |-> !(EVT_ZERO[0] | EVT_LOAD[0] |
    EVT_CMPA[0] | PIN_OUT_GEN_A[0]))
    else $error("disabled generator active");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID)
    else $error("read answer late");

  cover property (ctl_r == 2'h3 && EVT_LOAD[0]);
  cover property (EVT_CMPA[0]);
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule // pwg_top_monitor

bind pwg_top pwg_top_monitor i_mon (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RRESP(S_AXI_RRESP), .EVT_ZERO(EVT_ZERO), .EVT_LOAD(EVT_LOAD),
  .EVT_CMPA(EVT_CMPA), .EVT_CMPB(EVT_CMPB), .CNT_DIR(CNT_DIR),
  .PIN_OUT_GEN_A(PIN_OUT_GEN_A)
);
`default_nettype wire

// ==== bench/pwg_load_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwg_load_model (
  input wire logic       clk, // sampling clock
  input wire logic       clr, // clears rise counts
  input wire logic [3:0] drv  // gen0 a,b then gen1 a,b
);
  int rises [4];
  int width [4];
  int period [4];
  int hi_cnt [4];
  int since [4];
  logic [3:0] prev_r = 4'h0;

  // a switching load only sees levels: width, spacing, edge count
  always @(posedge clk)
  begin
    prev_r <= drv;
    for (int i = 0; i < 4; i++)
    begin
      hi_cnt[i] <= drv[i] ? hi_cnt[i] + 1 : 0;
      since[i] <= since[i] + 1;
      if (!drv[i] && prev_r[i])
        width[i] <= hi_cnt[i];
      if (drv[i] && !prev_r[i])
      begin
        period[i] <= since[i];
        since[i] <= 1;
      end
      if (clr)
        rises[i] <= 0;
      else if (drv[i] && !prev_r[i])
        rises[i] <= rises[i] + 1;
    end
  end
endmodule // pwg_load_model
`default_nettype wire

// ==== bench/test_pwg_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pwg_defs.vh"
module test_pwg_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  aw_addr = 8'h00;
  logic        aw_valid = 1'b0;
  logic [31:0] w_data = 32'h0;
  logic        w_valid = 1'b0;
  logic        b_ready = 1'b0;
  logic [7:0]  ar_addr = 8'h00;
  logic        ar_valid = 1'b0;
  logic        r_ready = 1'b0;
  logic        clr_stat = 1'b0;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0]  b_resp, r_resp, pin_a, pin_b;
  logic [31:0] r_data;
  int          failures = 0;
  int          n_tests = 0;

  pwg_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(aw_addr),
    .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
    .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
    .S_AXI_RREADY(r_ready), .PIN_OUT_GEN_A(pin_a), .PIN_OUT_GEN_B(pin_b),
    .EVT_ZERO(), .EVT_LOAD(), .EVT_CMPA(), .EVT_CMPB(), .CNT_DIR());
  pwg_load_model i_load (.clk(clk), .clr(clr_stat),
    .drv({pin_b[1], pin_a[1], pin_b[0], pin_a[0]}));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    failures++;
    $display("ERROR t=%0t bus answer missing", $time);
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (aw_ready)
        aw_valid <= 1'b0;
      if (w_ready)
        w_valid <= 1'b0;
      if (b_valid)
        break;
    end
    if (k == 50)
      hang();
    b_ready <= 1'b0;
    chk({30'h0, b_resp}, {30'h0, er});
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input logic [1:0] er);
    int k;
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (ar_ready)
        ar_valid <= 1'b0;
      if (r_valid)
        break;
    end
    if (k == 50)
      hang();
    r_ready <= 1'b0;
    chk(r_data & m, e);
    chk({30'h0, r_resp}, {30'h0, er});
    @(posedge clk);
  endtask

  // disable first so new limits apply at once, not at the next zero
  task automatic cfg(input logic [7:0] b, input logic [15:0] ld, ca, cb,
                     input logic [11:0] aa, ab, input logic [3:0] c);
    wr(b + `PWG_OFF_CTL, 32'h0, `PWG_RESP_OKAY);
    wr(b + `PWG_OFF_LOAD, {16'h0, ld}, `PWG_RESP_OKAY);
    wr(b + `PWG_OFF_CMPA, {16'h0, ca}, `PWG_RESP_OKAY);
    wr(b + `PWG_OFF_CMPB, {16'h0, cb}, `PWG_RESP_OKAY);
    wr(b + `PWG_OFF_ACTA, {20'h0, aa}, `PWG_RESP_OKAY);
    wr(b + `PWG_OFF_ACTB, {20'h0, ab}, `PWG_RESP_OKAY);
    wr(b + `PWG_OFF_CTL, {28'h0, c}, `PWG_RESP_OKAY);
  endtask

  task automatic settle(input int pre, input int post);
    repeat (pre) @(posedge clk);
    clr_stat <= 1'b1;
    @(posedge clk);
    clr_stat <= 1'b0;
    repeat (post) @(posedge clk);
  endtask

  task automatic s_regs();
    rdc(`PWG_OFF_LOAD, 32'hFFFFFFFF, 32'h0, `PWG_RESP_OKAY);
    wr(`PWG_OFF_LOAD, 32'h0001ABCD, `PWG_RESP_OKAY);
    rdc(`PWG_OFF_LOAD, 32'h0000FFFF, 32'hABCD, `PWG_RESP_OKAY);
    rdc(8'h1C, 32'hFFFFFFFF, 32'h0, `PWG_RESP_SLVERR);
    wr(8'h44, 32'h1, `PWG_RESP_SLVERR);
    rdc(`PWG_OFF_UPD, 32'hFFFFFFFF, 32'h0, `PWG_RESP_OKAY);
  endtask

  task automatic s_down();
    cfg(8'h00, 16'h9, 16'h4, 16'h7, 12'h083, 12'h803, 4'h1);
    settle(40, 40);
    chk(32'(i_load.period[0]), 32'hA);
    chk(32'(i_load.width[0]), 32'h6);
    chk(32'(i_load.width[1]), 32'h3);
  endtask

  task automatic s_updown();
    cfg(8'h00, 16'h9, 16'h4, 16'hC, 12'h0B0, 12'h300, 4'h3);
    settle(40, 60);
    chk(32'(i_load.period[0]), 32'h12);
    chk(32'(i_load.width[0]), 32'hA);
    chk(32'(i_load.rises[1]), 32'h0);
    wr(`PWG_OFF_CTL, 32'h0, `PWG_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({30'h0, pin_b[0], pin_a[0]}, 32'h0);
    rdc(`PWG_OFF_STAT, 32'h1FFFF, 32'h0, `PWG_RESP_OKAY);
  endtask

  task automatic s_coincide();
    cfg(8'h00, 16'h9, 16'h0, 16'hC, 12'h083, 12'h000, 4'h1);
    settle(40, 40);
    chk({31'h0, pin_a[0]}, 32'h1);
    chk(32'(i_load.rises[0]), 32'h0);
  endtask

  task automatic s_sync();
    cfg(8'h20, 16'h5, 16'hC, 16'hC, 12'h001, 12'h000, 4'h5);
    repeat (40) @(posedge clk);
    chk(32'(i_load.period[2]), 32'hC);
    wr(8'h20 + `PWG_OFF_LOAD, 32'h7, `PWG_RESP_OKAY);
    repeat (40) @(posedge clk);
    chk(32'(i_load.period[2]), 32'hC);
    rdc(8'h38, 32'h40000, 32'h40000, `PWG_RESP_OKAY);
    wr(`PWG_OFF_UPD, 32'h1, `PWG_RESP_OKAY);
    repeat (60) @(posedge clk);
    chk(32'(i_load.period[2]), 32'h10);
    rdc(8'h38, 32'h40000, 32'h0, `PWG_RESP_OKAY);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_regs();
    s_down();
    s_updown();
    s_coincide();
    s_sync();
    tally_and_finish();
  end
endmodule // test_pwg_top
`default_nettype wire
